// ==== lras_regs.sv ====
`timescale 1ns/1ns
// Receive and async control/status registers behind the byte-wide host port.
module lras_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic host_cs_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  input wire logic iso_pkt_valid,
  input lras_pkg::lras_pkt_s iso_pkt,
  input lras_pkg::lras_qlvl_s iso_buf_lvl,
  input lras_pkg::lras_qlvl_s rx_rsp_lvl,
  input lras_pkg::lras_qlvl_s rx_req_lvl,
  input lras_pkg::lras_qlvl_s tx_rsp_lvl,
  input lras_pkg::lras_qlvl_s tx_req_lvl,
  input wire logic tx_rsp_xfer_empty,
  input wire logic tx_req_xfer_empty,
  input wire logic link_sm_idle,
  input wire logic rsp_valid,
  input wire logic rsp_solicited,
  output logic rsp_store,
  output logic [5:0] listen_stream_number,
  output logic [1:0] iso_tag,
  output logic async_receiver_reset,
  output logic async_transmitter_reset,
  output logic accept_all_responses,
  output logic [3:0] retry_limit,
  output logic [15:0] split_timeout_limit
);
  import lras_pkg::*;

  lras_hpin_s pin_raw;
  lras_hpin_s sync1_r;
  lras_hpin_s sync2_r;
  lras_hpin_s prev_r;
  logic [1:0] rx_rate_code_r;
  logic [1:0] tag_r;
  logic [5:0] listen_stream_number_r;
  logic [3:0] err_r;
  logic [3:0] sync_r;
  lras_qflag_s iso_flags_r;
  logic arx_rst_r;
  logic atx_rst_r;
  logic acc_all_r;
  logic [3:0] retry_r;
  logic [15:0] tos_r;
  logic [ASY_MEM_W-1:0] asy_mem_r;
  logic [7:0] dout_r;
  logic oe_r;
  logic store_r;
  logic arx_rst_nxt;
  logic [ASY_MEM_W-1:0] asy_mem_nxt;

  wire rd_active;
  wire wr_evt;
  wire [1:0] wr_lane;
  wire [1:0] rd_lane;
  wire [31:0] lane_mask;
  wire [31:0] wr_data32;
  wire sel_irx_ctrl_w;
  wire sel_asy_ctrl_w;
  wire irx_ctrl_wr;
  wire asy_ctrl_wr;
  wire [31:0] irx_ctrl_word;
  wire [31:0] irx_buf_word;
  wire [31:0] asy_ctrl_word;
  wire [31:0] asy_mem_word;
  wire [31:0] irx_ctrl_wval;
  wire [31:0] asy_ctrl_wval;
  wire [31:0] rd_word;
  wire [7:0] rd_byte;
  wire pkt_match;
  wire [3:0] pkt_ack;
  wire pkt_accept;
  wire store_nxt;
  lras_qflag_s iso_flags_c;
  lras_qflag_s rx_rsp_c;
  lras_qflag_s rx_req_c;
  lras_qflag_s tx_rsp_c;
  lras_qflag_s tx_req_c;

  // Host pins are asynchronous to clk, so every one passes two flops first.
  assign pin_raw = '{cs_n: host_cs_n, rd_n: host_rd_n, wr_n: host_wr_n,
                     addr: host_addr, data: host_data_in};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 8'h00, data: 8'h00};
      sync2_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 8'h00, data: 8'h00};
      prev_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 8'h00, data: 8'h00};
    end else if (ce) begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // A write lands on the rising edge of the write strobe, using the address
  // and data seen while the strobe was still low, so bus settling cannot leak in.
  assign wr_evt = !prev_r.cs_n && !prev_r.wr_n && sync2_r.wr_n;
  assign rd_active = !sync2_r.cs_n && !sync2_r.rd_n;
  assign wr_lane = prev_r.addr[1:0];
  assign rd_lane = sync2_r.addr[1:0];
  assign lane_mask = 32'h0000_00FF << {wr_lane, 3'b000};
  assign wr_data32 = {4{prev_r.data}};
  assign sel_irx_ctrl_w = (prev_r.addr[7:2] == IRX_CTRL_OFS[7:2]);
  assign sel_asy_ctrl_w = (prev_r.addr[7:2] == ASY_CTRL_OFS[7:2]);
  assign irx_ctrl_wr = wr_evt && sel_irx_ctrl_w;
  assign asy_ctrl_wr = wr_evt && sel_asy_ctrl_w;

  // Register images as the host sees them; unused bits read as zero.
  assign irx_ctrl_word = {14'h0000, rx_rate_code_r, tag_r, listen_stream_number_r, err_r, sync_r};
  assign irx_buf_word = {28'h000_0000, iso_flags_r};
  assign asy_ctrl_word = {9'h000, arx_rst_r, atx_rst_r, acc_all_r, retry_r, tos_r};
  assign asy_mem_word = {14'h0000, asy_mem_r};

  // Byte writes merge into the word; read-only bits are protected by the mask.
  assign irx_ctrl_wval = (irx_ctrl_word & ~(lane_mask & IRX_CTRL_WMASK)) |
                         (wr_data32 & lane_mask & IRX_CTRL_WMASK);
  assign asy_ctrl_wval = (asy_ctrl_word & ~(lane_mask & ASY_CTRL_WMASK)) |
                         (wr_data32 & lane_mask & ASY_CTRL_WMASK);

  // Read selection; unmapped addresses return zero.
  assign rd_word = (sync2_r.addr[7:2] == IRX_CTRL_OFS[7:2]) ? irx_ctrl_word :
                   (sync2_r.addr[7:2] == IRX_BUF_OFS[7:2]) ? irx_buf_word :
                   (sync2_r.addr[7:2] == ASY_CTRL_OFS[7:2]) ? asy_ctrl_word :
                   (sync2_r.addr[7:2] == ASY_MEM_OFS[7:2]) ? asy_mem_word : 32'h0000_0000;
  assign rd_byte = rd_word[{rd_lane, 3'b000} +: 8];

  // The data bus is driven only while a read strobe is seen.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dout_r <= 8'h00;
      oe_r <= 1'b0;
    end else if (ce) begin
      dout_r <= rd_active ? rd_byte : 8'h00;
      oe_r <= rd_active;
    end
  end

  // Receive control: channel and tag are host-written.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tag_r <= IRX_CTRL_RST[TAG_LSB +: 2];
      listen_stream_number_r <= IRX_CTRL_RST[LISTEN_STREAM_NUMBER_LSB +: 6];
    end else if (ce && irx_ctrl_wr) begin
      tag_r <= irx_ctrl_wval[TAG_LSB +: 2];
      listen_stream_number_r <= irx_ctrl_wval[LISTEN_STREAM_NUMBER_LSB +: 6];
    end
  end

  lras_ack_eval u_ack (
    .pkt(iso_pkt),
    .channel(listen_stream_number_r),
    .tag(tag_r),
    .match(pkt_match),
    .ack(pkt_ack)
  );

  assign pkt_accept = iso_pkt_valid && pkt_match;

  // Last-packet fields hold until the next packet on our channel and tag.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_rate_code_r <= IRX_CTRL_RST[SPD_LSB +: 2];
      err_r <= IRX_CTRL_RST[ERR_LSB +: 4];
      sync_r <= IRX_CTRL_RST[SYNC_LSB +: 4];
    end else if (ce && pkt_accept) begin
      rx_rate_code_r <= iso_pkt.speed;
      err_r <= pkt_ack;
      sync_r <= iso_pkt.sync;
    end
  end

  // Fill flags for the receive buffer and the four async queues.
  lras_qflags u_iso_q (.lvl(iso_buf_lvl), .flags(iso_flags_c));
  lras_qflags u_rx_rsp_q (.lvl(rx_rsp_lvl), .flags(rx_rsp_c));
  lras_qflags u_rx_req_q (.lvl(rx_req_lvl), .flags(rx_req_c));
  lras_qflags u_tx_rsp_q (.lvl(tx_rsp_lvl), .flags(tx_rsp_c));
  lras_qflags u_tx_req_q (.lvl(tx_req_lvl), .flags(tx_req_c));

  // Status packing; flags lag the levels by one cycle.
  always_comb begin
    asy_mem_nxt = '0;
    asy_mem_nxt[TX_RSP_IDLE_BIT] = tx_rsp_xfer_empty;
    asy_mem_nxt[TX_REQ_IDLE_BIT] = tx_req_xfer_empty;
    asy_mem_nxt[RX_RSP_LSB +: 4] = rx_rsp_c;
    asy_mem_nxt[RX_REQ_LSB +: 4] = rx_req_c;
    asy_mem_nxt[TX_RSP_LSB +: 4] = tx_rsp_c;
    asy_mem_nxt[TX_REQ_LSB +: 4] = tx_req_c;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      iso_flags_r <= IRX_BUF_RST[3:0];
      asy_mem_r <= ASY_MEM_RST[ASY_MEM_W-1:0];
    end else if (ce) begin
      iso_flags_r <= iso_flags_c;
      asy_mem_r <= asy_mem_nxt;
    end
  end

  // The receiver reset bit clears itself once the link engine is idle, but a
  // host write in the same cycle wins so a fresh request is never lost.
  always_comb begin
    arx_rst_nxt = arx_rst_r && !link_sm_idle;
    if (asy_ctrl_wr) begin
      arx_rst_nxt = asy_ctrl_wval[ARX_RST_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arx_rst_r <= ASY_CTRL_RST[ARX_RST_BIT];
    end else if (ce) begin
      arx_rst_r <= arx_rst_nxt;
    end
  end

  // Remaining async control fields are plain host storage.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      atx_rst_r <= ASY_CTRL_RST[ATX_RST_BIT];
      acc_all_r <= ASY_CTRL_RST[ACC_ALL_BIT];
      retry_r <= ASY_CTRL_RST[RETRY_LSB +: 4];
      tos_r <= ASY_CTRL_RST[TOS_FRAC_LSB +: 16];
    end else if (ce && asy_ctrl_wr) begin
      atx_rst_r <= asy_ctrl_wval[ATX_RST_BIT];
      acc_all_r <= asy_ctrl_wval[ACC_ALL_BIT];
      retry_r <= asy_ctrl_wval[RETRY_LSB +: 4];
      tos_r <= asy_ctrl_wval[TOS_FRAC_LSB +: 16];
    end
  end

  // Responses are kept when all are accepted or when they were solicited;
  // a receiver held in reset stores nothing.
  assign store_nxt = rsp_valid && (acc_all_r || rsp_solicited) && !arx_rst_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      store_r <= 1'b0;
    end else if (ce) begin
      store_r <= store_nxt;
    end
  end

  // Outputs straight from flops.
  assign host_data_out = dout_r;
  assign host_data_oe = oe_r;
  assign rsp_store = store_r;
  assign listen_stream_number = listen_stream_number_r;
  assign iso_tag = tag_r;
  assign async_receiver_reset = arx_rst_r;
  assign async_transmitter_reset = atx_rst_r;
  assign accept_all_responses = acc_all_r;
  assign retry_limit = retry_r;
  assign split_timeout_limit = tos_r;

  // Checks.
  property p_speed_capture;
    @(posedge clk) disable iff (!rst_n)
      ce && pkt_accept |=> rx_rate_code_r == $past(iso_pkt.speed);
  endproperty
  a_speed_capture: assert property (p_speed_capture)
    else $error("Speed field did not capture accepted packet rate.");

  property p_data_error;
    @(posedge clk) disable iff (!rst_n)
      ce && pkt_accept && iso_pkt.has_payload && !iso_pkt.crc_ok |=> err_r == 4'hD;
  endproperty
  a_data_error: assert property (p_data_error)
    else $error("CRC failure did not report data error.");

  property p_no_payload_ok;
    @(posedge clk) disable iff (!rst_n)
      ce && pkt_accept && !iso_pkt.has_payload |=> err_r == 4'h1;
  endproperty
  a_no_payload_ok: assert property (p_no_payload_ok)
    else $error("Packet without payload reported an error.");

  property p_hold_fields;
    @(posedge clk) disable iff (!rst_n)
      !(ce && pkt_accept) |=> $stable(sync_r) && $stable(err_r) && $stable(rx_rate_code_r);
  endproperty
  a_hold_fields: assert property (p_hold_fields)
    else $error("Last-packet fields changed without an accepted packet.");

  property p_buf_full;
    @(posedge clk) disable iff (!rst_n)
      ce && iso_buf_lvl.free_q == 10'h000 |=> iso_flags_r.full && !iso_flags_r.five_free;
  endproperty
  a_buf_full: assert property (p_buf_full)
    else $error("Buffer full flag missing with no room left.");

  property p_buf_five;
    @(posedge clk) disable iff (!rst_n)
      ce && iso_buf_lvl.free_q >= 10'h005 |=> iso_flags_r.five_free && !iso_flags_r.one_left;
  endproperty
  a_buf_five: assert property (p_buf_five)
    else $error("Five-free flag missing.");

  property p_arx_clear;
    @(posedge clk) disable iff (!rst_n)
      ce && arx_rst_r && link_sm_idle && !asy_ctrl_wr |=> !async_receiver_reset;
  endproperty
  a_arx_clear: assert property (p_arx_clear)
    else $error("Receiver reset did not clear at idle.");

  property p_filter;
    @(posedge clk) disable iff (!rst_n)
      ce && rsp_valid && !rsp_solicited && !acc_all_r |=> !rsp_store;
  endproperty
  a_filter: assert property (p_filter)
    else $error("Unsolicited response stored while filtering.");

  property p_rx_rsp_vacant;
    @(posedge clk) disable iff (!rst_n)
      ce && rx_rsp_lvl.used_q == 10'h000 |=> asy_mem_r[12] ##0 asy_mem_word[31:18] == 14'h0000;
  endproperty
  a_rx_rsp_vacant: assert property (p_rx_rsp_vacant)
    else $error("Receive response empty flag missing.");

  // The channel lane is checked against the raw written byte, not the merge logic.
  property p_lane_write;
    @(posedge clk) disable iff (!rst_n)
      ce && wr_evt && prev_r.addr == IRX_CTRL_OFS + 8'h01 |=>
        listen_stream_number == $past(prev_r.data[5:0]) && iso_tag == $past(prev_r.data[7:6]);
  endproperty
  a_lane_write: assert property (p_lane_write)
    else $error("Channel and tag did not take the written byte.");

  property p_ctl_write;
    @(posedge clk) disable iff (!rst_n)
      ce && wr_evt && prev_r.addr == ASY_CTRL_OFS + 8'h02 |=>
        async_transmitter_reset == $past(prev_r.data[5]) &&
        retry_limit == $past(prev_r.data[3:0]);
  endproperty
  a_ctl_write: assert property (p_ctl_write)
    else $error("Transmitter reset or retry limit did not take the written byte.");

  property p_store_solicited;
    @(posedge clk) disable iff (!rst_n)
      ce && rsp_valid && rsp_solicited && !arx_rst_r |=> rsp_store;
  endproperty
  a_store_solicited: assert property (p_store_solicited)
    else $error("Solicited response was not stored.");
endmodule

// ==== lras_pkg.sv ====
package lras_pkg;
  // Register byte offsets.
  localparam logic [7:0] IRX_CTRL_OFS = 8'h54;
  localparam logic [7:0] IRX_BUF_OFS = 8'h58;
  localparam logic [7:0] ASY_CTRL_OFS = 8'h80;
  localparam logic [7:0] ASY_MEM_OFS = 8'h84;
  // Reset values.
  localparam logic [31:0] IRX_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] IRX_BUF_RST = 32'h0000_0003;
  localparam logic [31:0] ASY_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ASY_MEM_RST = 32'h0000_0000;
  // Software-writable bits of each control register.
  localparam logic [31:0] IRX_CTRL_WMASK = 32'h0000_FF00;
  localparam logic [31:0] ASY_CTRL_WMASK = 32'h007F_FFFF;
  // Field positions of the receive control register.
  localparam int SPD_LSB = 16;
  localparam int TAG_LSB = 14;
  localparam int LISTEN_STREAM_NUMBER_LSB = 8;
  localparam int ERR_LSB = 4;
  localparam int SYNC_LSB = 0;
  // Field positions of the async control register.
  localparam int ARX_RST_BIT = 22;
  localparam int ATX_RST_BIT = 21;
  localparam int ACC_ALL_BIT = 20;
  localparam int RETRY_LSB = 16;
  localparam int TOS_SEC_LSB = 13;
  localparam int TOS_FRAC_LSB = 0;
  // Field positions of the async queue status register.
  localparam int TX_RSP_IDLE_BIT = 17;
  localparam int TX_REQ_IDLE_BIT = 16;
  localparam int RX_RSP_LSB = 12;
  localparam int RX_REQ_LSB = 8;
  localparam int TX_RSP_LSB = 4;
  localparam int TX_REQ_LSB = 0;
  localparam int ASY_MEM_W = 18;
  // Codes.
  localparam logic [3:0] ACK_COMPLETE = 4'h1;
  localparam logic [3:0] ACK_DATA_ERROR = 4'hD;
  localparam logic [1:0] RATE_S100 = 2'h0;
  localparam logic [1:0] RATE_S200 = 2'h1;
  localparam logic [1:0] RATE_S400 = 2'h2;
  localparam logic [1:0] TAG_COMMON_AV = 2'h1;
  // Queue level width and the five-quadlet threshold.
  localparam int QLVL_W = 10;
  localparam logic [QLVL_W-1:0] FIVE_FREE_CNT = 10'h005;
  localparam logic [QLVL_W-1:0] ONE_FREE_CNT = 10'h001;
  // Fraction unit of the split timeout in hertz.
  localparam int SPLIT_FRAC_HZ = 8000;

  typedef struct packed {
    logic [5:0] channel;
    logic [1:0] tag;
    logic [1:0] speed;
    logic [3:0] sync;
    logic has_payload;
    logic crc_ok;
    logic [15:0] hdr_len;
    logic [15:0] rx_len;
  } lras_pkt_s;

  typedef struct packed {
    logic [QLVL_W-1:0] free_q;
    logic [QLVL_W-1:0] used_q;
  } lras_qlvl_s;

  typedef struct packed {
    logic full;
    logic one_left;
    logic five_free;
    logic vacant;
  } lras_qflag_s;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [7:0] addr;
    logic [7:0] data;
  } lras_hpin_s;
endpackage

// ==== lras_qflags.sv ====
`timescale 1ns/1ns
// Turns a queue's free and used quadlet counts into its four fill flags.
module lras_qflags (
  input lras_pkg::lras_qlvl_s lvl,
  output lras_pkg::lras_qflag_s flags
);
  import lras_pkg::*;

  // Flags follow the counts directly; the caller registers them.
  assign flags.full = (lvl.free_q == '0);
  assign flags.one_left = (lvl.free_q == ONE_FREE_CNT);
  assign flags.five_free = (lvl.free_q >= FIVE_FREE_CNT);
  assign flags.vacant = (lvl.used_q == '0);
endmodule

// ==== lras_ack_eval.sv ====
`timescale 1ns/1ns
// Decides whether a received packet is for us and which acknowledge code it earns.
module lras_ack_eval (
  input lras_pkg::lras_pkt_s pkt,
  input logic [5:0] channel,
  input logic [1:0] tag,
  output logic match,
  output logic [3:0] ack
);
  import lras_pkg::*;

  wire bad_crc;
  wire bad_len;

  // A packet counts only on the listened channel with the programmed tag.
  assign match = (pkt.channel == channel) && (pkt.tag == tag);
  // Errors are judged only when a data block payload is present.
  assign bad_crc = pkt.has_payload && !pkt.crc_ok;
  assign bad_len = pkt.has_payload && (pkt.hdr_len != pkt.rx_len);
  assign ack = (bad_crc || bad_len) ? ACK_DATA_ERROR : ACK_COMPLETE;
endmodule

// ==== lras_host_model.sv ====
`timescale 1ns/1ns
// Byte-wide host processor making strobed register cycles on the host pins.
module lras_host_model (
  input wire logic clk,
  input wire logic [7:0] dout,
  input wire logic oe,
  output lras_pkg::lras_hpin_s pins
);
  import lras_pkg::*;
  initial begin
    pins = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 8'h00, data: 8'h00};
  end

  // Wait a number of falling edges.
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Address and data stay put after the strobe rises so the synchronised copy still sees them.
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    pins = '{cs_n: 1'b0, rd_n: 1'b1, wr_n: 1'b0, addr: a, data: d};
    gap(4);
    pins.wr_n = 1'b1;
    gap(4);
    pins.cs_n = 1'b1;
    gap(4);
    pins.data = ~d;
    gap(1);
  endtask

  // A read samples the bus well after the three-cycle answer delay.
  task automatic rd8(input logic [7:0] a, output logic [7:0] d, output logic o);
    pins = '{cs_n: 1'b0, rd_n: 1'b0, wr_n: 1'b1, addr: a, data: ~pins.data};
    gap(5);
    d = dout;
    o = oe;
    pins.rd_n = 1'b1;
    gap(1);
    pins.cs_n = 1'b1;
    gap(4);
  endtask
endmodule

// ==== test_link_rx_async_status_regs.sv ====
`timescale 1ns/1ns
module test_link_rx_async_status_regs;
  import lras_pkg::*;
  logic clk, rst_n, ce, iso_pkt_valid, link_sm_idle, rsp_valid, rsp_solicited;
  logic tx_rsp_xfer_empty, tx_req_xfer_empty;
  lras_pkt_s iso_pkt;
  lras_qlvl_s iso_buf_lvl, rx_rsp_lvl, rx_req_lvl, tx_rsp_lvl, tx_req_lvl;
  lras_hpin_s pins;
  logic [7:0] host_data_out;
  logic host_data_oe, rsp_store, arx, atx, acc_all;
  logic [5:0] listen_stream_number;
  logic [1:0] iso_tag;
  logic [3:0] retry_limit;
  logic [15:0] split_timeout_limit;
  int num_errors = 0;
  int n_compared = 0;

  lras_host_model u_host (.clk(clk), .dout(host_data_out), .oe(host_data_oe), .pins(pins));
  lras_regs u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .host_cs_n(pins.cs_n),
    .host_rd_n(pins.rd_n), .host_wr_n(pins.wr_n), .host_addr(pins.addr),
    .host_data_in(pins.data), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .iso_pkt_valid(iso_pkt_valid), .iso_pkt(iso_pkt), .iso_buf_lvl(iso_buf_lvl),
    .rx_rsp_lvl(rx_rsp_lvl), .rx_req_lvl(rx_req_lvl), .tx_rsp_lvl(tx_rsp_lvl),
    .tx_req_lvl(tx_req_lvl), .tx_rsp_xfer_empty(tx_rsp_xfer_empty),
    .tx_req_xfer_empty(tx_req_xfer_empty), .link_sm_idle(link_sm_idle),
    .rsp_valid(rsp_valid), .rsp_solicited(rsp_solicited), .rsp_store(rsp_store),
    .listen_stream_number(listen_stream_number), .iso_tag(iso_tag),
    .async_receiver_reset(arx), .async_transmitter_reset(atx),
    .accept_all_responses(acc_all), .retry_limit(retry_limit),
    .split_timeout_limit(split_timeout_limit));

  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Reads one byte and also demands that the device drove the bus.
  task automatic rdb(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic o;
    u_host.rd8(a, d, o);
    chk({31'h0, o}, 32'h1, "drive");
    chk({24'h0, d}, {24'h0, e}, $sformatf("read %h", a));
    chk({31'h0, host_data_oe}, 32'h0, "release");
  endtask

  task automatic send(input logic [5:0] ch, input logic [1:0] tg, input logic [1:0] sp,
      input logic [3:0] sy, input logic pay, input logic crc, input logic [15:0] rl);
    @(negedge clk);
    iso_pkt = '{ch, tg, sp, sy, pay, crc, 16'h0010, rl};
    iso_pkt_valid = 1'b1;
    @(negedge clk);
    iso_pkt_valid = 1'b0;
  endtask

  // The store decision stands in the cycle after the response pulse.
  task automatic rsp(input logic sol, input logic e);
    @(negedge clk);
    rsp_valid = 1'b1;
    rsp_solicited = sol;
    @(negedge clk);
    rsp_valid = 1'b0;
    chk({31'h0, rsp_store}, {31'h0, e}, "store");
  endtask

  task automatic t_reset();
    rdb(8'h54, 8'h00);
    rdb(8'h56, 8'h00);
    rdb(8'h58, 8'h03);
    rdb(8'h82, 8'h00);
    rdb(8'h84, 8'h00);
    rdb(8'h86, 8'h00);
    rdb(8'h60, 8'h00);
    $display("test reset done");
  endtask

  // Read-only lanes ignore writes, the tag and channel lane takes them.
  task automatic t_ctrl();
    u_host.wr8(8'h54, 8'hFF);
    u_host.wr8(8'h56, 8'hFF);
    u_host.wr8(8'h55, 8'h6A);
    chk({26'h0, listen_stream_number}, 32'h2A, "listen_stream_number");
    chk({30'h0, iso_tag}, 32'h1, "tag");
    rdb(8'h55, 8'h6A);
    rdb(8'h54, 8'h00);
    rdb(8'h56, 8'h00);
    $display("test ctrl done");
  endtask

  task automatic t_pkt();
    for (int s = 0; s < 3; s++) begin
      send(6'h2A, 2'h1, s[1:0], 4'(s + 5), 1'b1, 1'b1, 16'h0010);
      rdb(8'h56, {6'h0, s[1:0]});
      rdb(8'h54, {4'h1, 4'(s + 5)});
    end
    // A rejected packet right behind an accepted one must leave the fields alone.
    send(6'h2A, 2'h1, 2'h1, 4'h9, 1'b1, 1'b0, 16'h0010);
    send(6'h2B, 2'h1, 2'h2, 4'hF, 1'b1, 1'b1, 16'h0010);
    rdb(8'h54, 8'hD9);
    rdb(8'h56, 8'h01);
    send(6'h2A, 2'h1, 2'h0, 4'h3, 1'b1, 1'b1, 16'h000C);
    send(6'h2A, 2'h0, 2'h2, 4'hE, 1'b1, 1'b1, 16'h0010);
    rdb(8'h54, 8'hD3);
    send(6'h2A, 2'h1, 2'h2, 4'h7, 1'b0, 1'b0, 16'h000C);
    rdb(8'h54, 8'h17);
    rdb(8'h56, 8'h02);
    $display("test pkt done");
  endtask

  task automatic t_buf();
    logic [9:0] fr [4] = '{10'd0, 10'd1, 10'd5, 10'd4};
    logic [9:0] us [4] = '{10'd50, 10'd40, 10'd0, 10'd3};
    logic [7:0] ex [4] = '{8'h08, 8'h04, 8'h03, 8'h00};
    for (int i = 0; i < 4; i++) begin
      iso_buf_lvl = '{fr[i], us[i]};
      rdb(8'h58, ex[i]);
    end
    rdb(8'h59, 8'h00);
    $display("test buf done");
  endtask

  task automatic t_async_queue_status();
    rx_rsp_lvl = '{10'd0, 10'd9};
    rx_req_lvl = '{10'd1, 10'd8};
    tx_rsp_lvl = '{10'd5, 10'd0};
    tx_req_lvl = '{10'd7, 10'd2};
    for (int k = 0; k < 2; k++) begin
      tx_rsp_xfer_empty = (k == 0);
      tx_req_xfer_empty = (k == 1);
      rdb(8'h84, 8'h32);
      rdb(8'h85, 8'h84);
      rdb(8'h86, (k == 0) ? 8'h02 : 8'h01);
      rdb(8'h87, 8'h00);
    end
    // An emptied response queue and a filled request queue move the other flags.
    rx_rsp_lvl = '{10'd3, 10'd0};
    rx_req_lvl = '{10'd0, 10'd4};
    tx_req_lvl = '{10'd1, 10'd0};
    rdb(8'h84, 8'h35);
    rdb(8'h85, 8'h18);
    $display("test async_queue_status done");
  endtask

  task automatic t_async_engine_control();
    u_host.wr8(8'h80, 8'h34);
    u_host.wr8(8'h81, 8'hB2);
    chk({16'h0, split_timeout_limit}, 32'hB234, "timeout");
    rdb(8'h81, 8'hB2);
    u_host.wr8(8'h82, 8'h3C);
    chk({25'h0, arx, atx, acc_all, retry_limit}, 32'h3C, "ctl");
    rsp(1'b0, 1'b1);
    u_host.wr8(8'h82, 8'h2C);
    chk({28'h0, retry_limit}, 32'hC, "retry");
    rsp(1'b0, 1'b0);
    rsp(1'b1, 1'b1);
    // Receiver reset must hold while the link engine is busy.
    u_host.wr8(8'h82, 8'h6C);
    chk({25'h0, arx, atx, acc_all, retry_limit}, 32'h6C, "ctl");
    rsp(1'b1, 1'b0);
    repeat (6) @(negedge clk);
    chk({31'h0, arx}, 32'h1, "rx reset held");
    link_sm_idle = 1'b1;
    repeat (3) @(negedge clk);
    chk({31'h0, arx}, 32'h0, "rx reset cleared");
    link_sm_idle = 1'b0;
    rdb(8'h82, 8'h2C);
    u_host.wr8(8'h83, 8'hFF);
    rdb(8'h83, 8'h00);
    $display("test async_engine_control done");
  endtask

  // With the clock enable low nothing may move, not even an accepted packet.
  task automatic t_freeze();
    @(negedge clk);
    ce = 1'b0;
    send(6'h2A, 2'h1, 2'h1, 4'h4, 1'b0, 1'b0, 16'h0000);
    repeat (2) @(negedge clk);
    ce = 1'b1;
    rdb(8'h54, 8'h17);
    rdb(8'h56, 8'h02);
    // A reset in mid-run must return the written controls to zero.
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    chk({16'h0, split_timeout_limit}, 32'h0, "tos reset");
    rdb(8'h55, 8'h00);
    rdb(8'h82, 8'h00);
    $display("test freeze done");
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog: the whole run needs well under 5000 cycles.
  initial begin
    #100000;
    num_errors++;
    $display("BAD t=%0t watchdog expired", $time);
    summarize();
  end

  // Main sequence.
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    iso_pkt_valid = 1'b0;
    iso_pkt = '0;
    link_sm_idle = 1'b0;
    rsp_valid = 1'b0;
    rsp_solicited = 1'b0;
    tx_rsp_xfer_empty = 1'b0;
    tx_req_xfer_empty = 1'b0;
    iso_buf_lvl = '{10'd100, 10'd0};
    rx_rsp_lvl = '{10'd2, 10'd1};
    rx_req_lvl = '{10'd2, 10'd1};
    tx_rsp_lvl = '{10'd2, 10'd1};
    tx_req_lvl = '{10'd2, 10'd1};
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_ctrl();
    t_pkt();
    t_buf();
    t_async_queue_status();
    t_async_engine_control();
    t_freeze();
    summarize();
  end
endmodule
